/* src/pssm_pkg.sv */
// Shared constants and types of the phase sync and supervisor block.
package pssm_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ        = 250000;
   localparam int STRAP_TIME_NS  = 2000;
   localparam int STRAP_CYC      = (STRAP_TIME_NS * CLK_KHZ + 999999) / 1000000;
   localparam int PULSE_TIME_NS  = 200;
   localparam int PULSE_CYC      = (PULSE_TIME_NS * CLK_KHZ + 999999) / 1000000;
   localparam int FOLLOW_KHZ     = 250;
   localparam int FOLLOW_PERIOD  = CLK_KHZ / FOLLOW_KHZ;
   localparam int STAY_KHZ       = 275;
   localparam int STAY_PERIOD    = CLK_KHZ / STAY_KHZ;
   localparam int FAST_PULSES    = 10;
   localparam int SPREAD_NUM     = 10;
   localparam int SPREAD_DEN     = 11;
   localparam int GUARD_CYC      = 16;
   localparam int CNT_W          = 12;

   // ----------------------------------------------------------------
   // Supervisor thresholds in percent of nominal output
   // ----------------------------------------------------------------
   localparam logic [7:0] THR_80 = 8'h50;
   localparam logic [7:0] THR_87 = 8'h57;
   localparam logic [7:0] THR_93 = 8'h5D;
   localparam logic [7:0] THR_96 = 8'h60;

   // ----------------------------------------------------------------
   // Register map and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0]  REG_CTRL_OFS   = 4'h0;
   localparam logic [3:0]  REG_STATUS_OFS = 4'h4;
   localparam logic [15:0] DELAY_RST      = 16'h0400;

   // Latched strap selections.
   typedef struct packed {
      logic       low_consumption_operation;
      logic [1:0] thr;
      logic [2:0] fsel;
   } pssm_strap_type;

   // Power-up phase and sync role.
   typedef enum logic [0:0] {PH_STRAP, PH_RUN} pssm_phase_type;
   typedef enum logic [1:0] {ROLE_LEAD, ROLE_FOLLOW, ROLE_RETURN,
                             ROLE_LATCHED} pssm_role_type;

endpackage

/* src/pssm_sync3.sv */
// Three-flop input synchroniser with second/third stage agreement filter.
`timescale 1ns/1ps
`default_nettype none
module pssm_sync3
#(
   parameter int W = 1
)
(
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output var  logic [W-1:0] q_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // ----------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------
   // The first stage feeds only the second; a change is taken once
   // the second and third stages agree.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q_o  <= '0;
      end
      else
      begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            q_o <= s3_q;
      end
   end
endmodule // pssm_sync3
`default_nettype wire

/* src/pssm_top.sv */
// Strap latch, power-good supervisor and sync line role control.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
//Operation
//- Straps are sampled and latched once before soft-start is enabled.
//- Frequency strap pin is released to float after sampling.
//- Unstrapped mode codes give low-noise or low-consumption, both 93%.
//- Power-good is pulled low while output is out of regulation.
//- Supervisor threshold is one of 80, 87, 93 or 96 percent.
//- Delay ramp starts in regulation, releases at end, restarts on loss.
//- Followers on a joined line switch 180 degrees from the lead.
//- With an external reference, switching is in phase with it.
//- Default lead role drives the line at the strap frequency.
//- Follower runs its oscillator at 250 kHz and drives the line.
//- Ten fast pulses beyond the spread make the device a follower.
//- Follower stays above 275 kHz, else one 250 kHz pulse, then lead.
//- Line low at power-up latches follower until the next lockout.
//- Slope setting comes from the frequency strap and stays fixed.
module pssm_top
(
   input  wire logic        MCLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        LINK_CLK_I,
   input  wire logic [2:0]  MODE_THRESHOLD_STRAP_I,
   input  wire logic [2:0]  FREQUENCY_STRAP_I,
   output var  logic        FREQUENCY_STRAP_O,
   output var  logic        FREQUENCY_STRAP_OE_O,
   input  wire logic [7:0]  FEEDBACK_NODE_I,
   input  wire logic        PHASE_LOCK_LINE_I,
   output var  logic        PHASE_LOCK_LINE_O,
   output var  logic        PHASE_LOCK_LINE_OE_O,
   output var  logic        SOFT_START_O,
   output var  logic        SWITCH_O,
   output var  logic        LCM_O,
   output var  logic [1:0]  THRESH_SEL_O,
   output var  logic [2:0]  SLOPE_SEL_O,
   output var  logic        PGOOD_O,
   output var  logic        PGOOD_OE_O,
   input  wire logic [3:0]  ADDR_I,
   input  wire logic [31:0] WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   output var  logic [31:0] RDATA_O
);
   localparam logic [11:0] PULSE_LAST = 12'(pssm_pkg::PULSE_CYC - 1);
   localparam logic [11:0] FOL_LAST   = 12'(pssm_pkg::FOLLOW_PERIOD - 1);
   localparam logic [11:0] STAY_LIM   = 12'(pssm_pkg::STAY_PERIOD);
   localparam logic [11:0] GUARD_LAST = 12'(pssm_pkg::GUARD_CYC);
   localparam logic [11:0] STRAP_LAST = 12'(pssm_pkg::STRAP_CYC - 1);
   localparam logic [3:0]  FAST_LAST  = 4'(pssm_pkg::FAST_PULSES - 1);

   // ----------------------------------------------------------------
   // Decode functions
   // ----------------------------------------------------------------
   // Typical oscillator period in core cycles for a frequency code.
   function automatic logic [11:0] freq_period(input logic [2:0] code);
      case (code)
         3'h0:    freq_period = 12'h3E8;
         3'h1:    freq_period = 12'h1F4;
         3'h2:    freq_period = 12'h14D;
         3'h3:    freq_period = 12'h0FA;
         3'h4:    freq_period = 12'h0C8;
         3'h5:    freq_period = 12'h0A6;
         3'h6:    freq_period = 12'h08E;
         default: freq_period = 12'h07D;
      endcase
   endfunction

   // Shortest period still inside the oscillator spread.
   function automatic logic [11:0] fast_limit(input logic [2:0] code);
      logic [23:0] p;
      p = 24'(freq_period(code)) * 24'(pssm_pkg::SPREAD_NUM);
      fast_limit = 12'(p / 24'(pssm_pkg::SPREAD_DEN));
   endfunction

   // Threshold percent for a threshold index.
   function automatic logic [7:0] thr_pct(input logic [1:0] idx);
      case (idx)
         2'h0:    thr_pct = pssm_pkg::THR_80;
         2'h1:    thr_pct = pssm_pkg::THR_87;
         2'h2:    thr_pct = pssm_pkg::THR_93;
         default: thr_pct = pssm_pkg::THR_96;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [15:0]              core_sync;
   logic [2:0]               mode_s;
   logic [2:0]               fsel_s;
   logic [7:0]               fb_s;
   logic                     line_lvl_s;
   logic                     line_tog_s;
   logic                     link_line;
   logic [1:0]               link_rst_q;
   logic                     link_tog_q;
   logic                     link_prev_q;
   logic                     tog_prev_q;
   logic                     ext_edge;
   pssm_pkg::pssm_phase_type phase_q;
   pssm_pkg::pssm_role_type  role_q;
   pssm_pkg::pssm_strap_type strap_q;
   logic [11:0]              strap_cnt_q;
   logic [11:0]              osc_cnt_q;
   logic [11:0]              gap_cnt_q;
   logic [11:0]              pulse_cnt_q;
   logic [11:0]              guard_cnt_q;
   logic [3:0]               fast_cnt_q;
   logic [11:0]              period;
   logic                     osc_wrap;
   logic                     pulse_start;
   logic                     pulse_end;
   logic                     in_reg_q;
   logic [15:0]              dly_cnt_q;
   logic [15:0]              dly_term_q;

   // ----------------------------------------------------------------
   // Link domain: sample the line and pass rising edges as a toggle
   // ----------------------------------------------------------------
   // Reset is carried into the link domain through two flops.
   always_ff @(posedge LINK_CLK_I)
   begin
      link_rst_q <= {link_rst_q[0], RST_N_I};
   end

   pssm_sync3 #(.W(1)) u_link_sync
   (
      .clk_i   (LINK_CLK_I),
      .rst_n_i (link_rst_q[1]),
      .d_i     (PHASE_LOCK_LINE_I),
      .q_o     (link_line)
   );

   // Each rising edge of the line flips the toggle once.
   always_ff @(posedge LINK_CLK_I)
   begin
      if (!link_rst_q[1])
      begin
         link_prev_q <= 1'b0;
         link_tog_q  <= 1'b0;
      end
      else
      begin
         link_prev_q <= link_line;
         if (link_line && !link_prev_q)
            link_tog_q <= ~link_tog_q;
      end
   end

   // ----------------------------------------------------------------
   // Core domain synchronisers for pins and link events
   // ----------------------------------------------------------------
   pssm_sync3 #(.W(16)) u_core_sync
   (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .d_i     ({MODE_THRESHOLD_STRAP_I, FREQUENCY_STRAP_I,
                 FEEDBACK_NODE_I, link_line, link_tog_q}),
      .q_o     (core_sync)
   );

   assign mode_s     = core_sync[15:13];
   assign fsel_s     = core_sync[12:10];
   assign fb_s       = core_sync[9:2];
   assign line_lvl_s = core_sync[1];
   assign line_tog_s = core_sync[0];

   // A foreign edge is one that arrives while this end is not driving.
   // Edges in the strap phase are dropped: the line synchroniser leaves
   // reset low and would otherwise report a false edge on an idle line.
   assign ext_edge = (line_tog_s != tog_prev_q) && !PHASE_LOCK_LINE_OE_O
                     && (guard_cnt_q == 12'h000)
                     && (phase_q == pssm_pkg::PH_RUN);

   // ----------------------------------------------------------------
   // Power-up strap phase
   // ----------------------------------------------------------------
   // Straps and the line level are taken once at the end of the strap
   // window, before soft-start; the strap bias is then released.
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         phase_q              <= pssm_pkg::PH_STRAP;
         strap_cnt_q          <= 12'h000;
         strap_q              <= '0;
         SOFT_START_O         <= 1'b0;
         FREQUENCY_STRAP_O    <= 1'b0;
         FREQUENCY_STRAP_OE_O <= 1'b1;
      end
      else if (phase_q == pssm_pkg::PH_STRAP)
      begin
         strap_cnt_q <= strap_cnt_q + 12'h001;
         if (strap_cnt_q == STRAP_LAST)
         begin
            phase_q      <= pssm_pkg::PH_RUN;
            strap_q.fsel <= fsel_s;
            SOFT_START_O <= 1'b1;
            FREQUENCY_STRAP_OE_O <= 1'b0;
            case (mode_s)
               3'h0:    {strap_q.low_consumption_operation, strap_q.thr} <= {1'b0, 2'h2};
               3'h1:    {strap_q.low_consumption_operation, strap_q.thr} <= {1'b1, 2'h2};
               3'h2:    {strap_q.low_consumption_operation, strap_q.thr} <= {1'b0, 2'h0};
               3'h3:    {strap_q.low_consumption_operation, strap_q.thr} <= {1'b1, 2'h0};
               3'h4:    {strap_q.low_consumption_operation, strap_q.thr} <= {1'b0, 2'h1};
               3'h5:    {strap_q.low_consumption_operation, strap_q.thr} <= {1'b1, 2'h1};
               3'h6:    {strap_q.low_consumption_operation, strap_q.thr} <= {1'b0, 2'h3};
               default: {strap_q.low_consumption_operation, strap_q.thr} <= {1'b1, 2'h3};
            endcase
         end
      end
   end

   // Latched selections drive the mode, threshold and slope outputs.
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         LCM_O        <= 1'b0;
         THRESH_SEL_O <= 2'h0;
         SLOPE_SEL_O  <= 3'h0;
      end
      else
      begin
         LCM_O        <= strap_q.low_consumption_operation;
         THRESH_SEL_O <= strap_q.thr;
         SLOPE_SEL_O  <= strap_q.fsel;
      end
   end

   // ----------------------------------------------------------------
   // Supervisor and power-good delay
   // ----------------------------------------------------------------
   // In regulation once feedback reaches the selected threshold.
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         in_reg_q <= 1'b0;
      else
         in_reg_q <= (phase_q == pssm_pkg::PH_RUN)
                     && (fb_s >= thr_pct(strap_q.thr));
   end

   // The delay counter runs in regulation and restarts on any loss.
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         dly_cnt_q  <= 16'h0000;
         PGOOD_OE_O <= 1'b1;
         PGOOD_O    <= 1'b0;
      end
      else if (!in_reg_q)
      begin
         dly_cnt_q  <= 16'h0000;
         PGOOD_OE_O <= 1'b1;
      end
      else if (dly_cnt_q >= dly_term_q)
         PGOOD_OE_O <= 1'b0;
      else
         dly_cnt_q <= dly_cnt_q + 16'h0001;
   end

   // ----------------------------------------------------------------
   // Oscillator, gap timer and line pulse
   // ----------------------------------------------------------------
   assign period = (role_q == pssm_pkg::ROLE_LEAD) ? freq_period(strap_q.fsel)
                                                   : FOL_LAST + 12'h001;
   assign osc_wrap    = (osc_cnt_q >= period - 12'h001);
   assign pulse_end   = PHASE_LOCK_LINE_OE_O && (pulse_cnt_q == PULSE_LAST);
   // Lead pulses at mid-period; followers only when no edge came in.
   assign pulse_start = (phase_q == pssm_pkg::PH_RUN) && !PHASE_LOCK_LINE_OE_O
                        && ((role_q == pssm_pkg::ROLE_LEAD)
                            ? (osc_cnt_q == {1'b0, period[11:1]})
                            : osc_wrap);

   // Followers restart the period on a fast foreign edge. A lead also
   // restarts on each edge that counts toward follower role, so that its
   // own pulse and guard cannot keep hiding every few foreign edges.
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         osc_cnt_q <= 12'h000;
         SWITCH_O  <= 1'b0;
      end
      else if (phase_q != pssm_pkg::PH_RUN)
      begin
         osc_cnt_q <= 12'h000;
         SWITCH_O  <= 1'b0;
      end
      else if (ext_edge
               && (((gap_cnt_q < STAY_LIM)
                    && ((role_q == pssm_pkg::ROLE_FOLLOW)
                        || (role_q == pssm_pkg::ROLE_LATCHED)))
                   || ((role_q == pssm_pkg::ROLE_LEAD)
                       && (gap_cnt_q < fast_limit(strap_q.fsel)))))
      begin
         osc_cnt_q <= 12'h000;
         SWITCH_O  <= 1'b1;
      end
      else if (osc_wrap || (pulse_end && role_q == pssm_pkg::ROLE_RETURN))
      begin
         osc_cnt_q <= 12'h000;
         SWITCH_O  <= 1'b1;
      end
      else
      begin
         osc_cnt_q <= osc_cnt_q + 12'h001;
         SWITCH_O  <= 1'b0;
      end
   end

   // Gap timer between foreign edges, and the toggle edge memory.
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         gap_cnt_q  <= 12'hFFF;
         tog_prev_q <= 1'b0;
      end
      else
      begin
         tog_prev_q <= line_tog_s;
         if (ext_edge)
            gap_cnt_q <= 12'h001;
         else if (gap_cnt_q != 12'hFFF)
            gap_cnt_q <= gap_cnt_q + 12'h001;
      end
   end

   // Line pulse of fixed width, then a guard against its own echo.
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         PHASE_LOCK_LINE_OE_O <= 1'b0;
         PHASE_LOCK_LINE_O    <= 1'b0;
         pulse_cnt_q          <= 12'h000;
         guard_cnt_q          <= 12'h000;
      end
      else if (pulse_start)
      begin
         PHASE_LOCK_LINE_OE_O <= 1'b1;
         PHASE_LOCK_LINE_O    <= 1'b1;
         pulse_cnt_q          <= 12'h000;
      end
      else if (pulse_end)
      begin
         PHASE_LOCK_LINE_OE_O <= 1'b0;
         PHASE_LOCK_LINE_O    <= 1'b0;
         guard_cnt_q          <= GUARD_LAST;
      end
      else
      begin
         pulse_cnt_q <= pulse_cnt_q + 12'h001;
         if (guard_cnt_q != 12'h000)
            guard_cnt_q <= guard_cnt_q - 12'h001;
      end
   end

   // ----------------------------------------------------------------
   // Sync role
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         role_q     <= pssm_pkg::ROLE_LEAD;
         fast_cnt_q <= 4'h0;
      end
      else if (phase_q == pssm_pkg::PH_STRAP)
      begin
         if (strap_cnt_q == STRAP_LAST && !line_lvl_s)
            role_q <= pssm_pkg::ROLE_LATCHED;
      end
      else
      begin
         case (role_q)
            pssm_pkg::ROLE_LEAD:
            begin
               if (ext_edge && gap_cnt_q < fast_limit(strap_q.fsel))
               begin
                  fast_cnt_q <= fast_cnt_q + 4'h1;
                  if (fast_cnt_q == FAST_LAST)
                  begin
                     role_q     <= pssm_pkg::ROLE_FOLLOW;
                     fast_cnt_q <= 4'h0;
                  end
               end
               else if (ext_edge)
                  fast_cnt_q <= 4'h0;
            end
            pssm_pkg::ROLE_FOLLOW:
            begin
               if ((ext_edge && gap_cnt_q >= STAY_LIM) || pulse_start)
                  role_q <= pssm_pkg::ROLE_RETURN;
            end
            pssm_pkg::ROLE_RETURN:
            begin
               if (pulse_end)
                  role_q <= pssm_pkg::ROLE_LEAD;
            end
            pssm_pkg::ROLE_LATCHED:
               role_q <= pssm_pkg::ROLE_LATCHED;
            default:
               role_q <= pssm_pkg::ROLE_LEAD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         dly_term_q <= pssm_pkg::DELAY_RST;
      else if (WR_I && ADDR_I == pssm_pkg::REG_CTRL_OFS)
         dly_term_q <= WDATA_I[15:0];
   end

   // Read data stand in the cycle after the strobe only.
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I || !RD_I)
         RDATA_O <= 32'h0000_0000;
      else if (ADDR_I == pssm_pkg::REG_CTRL_OFS)
         RDATA_O <= {16'h0000, dly_term_q};
      else if (ADDR_I == pssm_pkg::REG_STATUS_OFS)
         RDATA_O <= {21'h000000, strap_q, role_q, in_reg_q,
                     ~PGOOD_OE_O, phase_q};
      else
         RDATA_O <= 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_loss;
      !in_reg_q;
   endsequence
   sequence s_held_low;
      PGOOD_OE_O [*2];
   endsequence

   a_strap_fixed:
      assert property ((phase_q == pssm_pkg::PH_RUN) |=> $stable(strap_q))
      else $error("Strap selection changed after soft-start.");
   a_strap_float:
      assert property (SOFT_START_O |-> !FREQUENCY_STRAP_OE_O)
      else $error("Frequency strap pin still driven after sampling.");
   a_pgood_loss:
      assert property (s_loss |=> s_held_low)
      else $error("Power-good released while out of regulation.");
   a_pgood_delay:
      assert property ($fell(PGOOD_OE_O) |-> $past(dly_cnt_q) >= dly_term_q)
      else $error("Power-good released before delay end.");
   a_follow_entry:
      assert property ((role_q == pssm_pkg::ROLE_LEAD) ##1
                       (role_q == pssm_pkg::ROLE_FOLLOW)
                       |-> $past(fast_cnt_q) == FAST_LAST)
      else $error("Follower role entered without ten fast pulses.");
   a_latch_sticky:
      assert property ((role_q == pssm_pkg::ROLE_LATCHED)
                       |=> (role_q == pssm_pkg::ROLE_LATCHED))
      else $error("Latched follower role left.");
   a_follow_phase:
      assert property ((role_q == pssm_pkg::ROLE_FOLLOW) && ext_edge
                       && (gap_cnt_q < STAY_LIM)
                       |=> SWITCH_O && (osc_cnt_q == 12'h000))
      else $error("Follower not aligned to line edge.");
   a_lead_pulse:
      assert property ($rose(PHASE_LOCK_LINE_OE_O)
                       && (role_q == pssm_pkg::ROLE_LEAD)
                       |-> PHASE_LOCK_LINE_OE_O [*8])
      else $error("Lead line pulse too short.");
   a_return_lead:
      assert property ((role_q == pssm_pkg::ROLE_RETURN) && pulse_end
                       |=> (role_q == pssm_pkg::ROLE_LEAD)
                           && !PHASE_LOCK_LINE_OE_O)
      else $error("Return to lead did not follow the pulse.");
endmodule // pssm_top
`default_nettype wire

/* test/pssm_ext.sv */
// External clock source model for the shared sync line.
`timescale 1ns/1ps
`default_nettype none
module pssm_ext
#(
   parameter int PER = 139
)
(
   input  wire logic lclk_i,
   input  wire logic run_i,
   input  wire logic hold_i,
   output var  logic q_o,
   output var  logic oe_o
);
   int c_q = 0;
   // Period of 139 link cycles, about 600 kHz.
   always_ff @(posedge lclk_i)
      c_q <= (!run_i || c_q == PER - 1) ? 0 : c_q + 1;
   // Pulse 108 ns wide; line held low.
   assign oe_o = run_i | hold_i;
   assign q_o  = run_i & ~hold_i & (c_q < 9);
endmodule // pssm_ext
`default_nettype wire

/* test/tb.sv */
// Bench for strap latch, supervisor and sync role control.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk = 0, lclk = 0, rst_n = 0, wr = 0, rd = 0, run = 0, hold = 0;
   logic [2:0] mode = 0, fs = 0, ss, f;
   logic [7:0] fb = 0;
   logic [3:0] addr = 0;
   logic [31:0] wd = 0, d, rdat, seed = 32'hE1D36144;
   logic eq, eoe, lq, loe, so, sw, low_consumption_operation, pg, pgoe, fq, foe;
   logic [1:0] th;
   int err_count = 0, tests_run = 0, n;
   // Pull-up on the line; any low driver wins.
   wire line = ~((eoe & ~eq) | (loe & ~lq));
   always #2 mclk = ~mclk;
   initial
   begin
      #1.3;
      forever #6 lclk = ~lclk;
   end
   pssm_ext EXT (.lclk_i(lclk), .run_i(run), .hold_i(hold), .q_o(eq),
      .oe_o(eoe));
   pssm_top DUT (.MCLK_I(mclk), .RST_N_I(rst_n), .LINK_CLK_I(lclk),
      .MODE_THRESHOLD_STRAP_I(mode), .FREQUENCY_STRAP_I(fs),
      .FREQUENCY_STRAP_O(fq), .FREQUENCY_STRAP_OE_O(foe),
      .FEEDBACK_NODE_I(fb), .PHASE_LOCK_LINE_I(line),
      .PHASE_LOCK_LINE_O(lq), .PHASE_LOCK_LINE_OE_O(loe),
      .SOFT_START_O(so), .SWITCH_O(sw), .LCM_O(low_consumption_operation), .THRESH_SEL_O(th),
      .SLOPE_SEL_O(ss), .PGOOD_O(pg), .PGOOD_OE_O(pgoe), .ADDR_I(addr),
      .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [1:0] thr_of(input logic [2:0] m);
      return (m < 2) ? 2'h2 : (m < 4) ? 2'h0 : (m < 6) ? 2'h1 : 2'h3;
   endfunction
   // Supervisor threshold in percent for a threshold index.
   function automatic logic [7:0] pct(input logic [1:0] t);
      return (t == 0) ? 8'h50 : (t == 1) ? 8'h57 : (t == 2) ? 8'h5D : 8'h60;
   endfunction
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   // One settled cycle; a wait that runs out ends the run.
   task automatic tick(inout int c, input int lim);
      @(posedge mclk);
      #1;
      c++;
      if (c >= lim)
      begin
         err_count++;
         summarize();
      end
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdat;
   endtask
   // Cycles up to the next switching pulse.
   task automatic gap();
      n = 0;
      do tick(n, 3000); while (sw !== 1'b1);
   endtask
   task automatic do_reset(input logic [2:0] m, input logic h);
      rst_n <= 1'b0;
      mode <= m;
      fs <= f;
      hold <= h;
      n = 0;
      repeat (13) tick(n, 20);
      chk(foe, 1'b1);
      chk(pgoe, 1'b1);
      rst_n <= 1'b1;
      n = 0;
      while (so !== 1'b1) tick(n, 600);
      hold <= 1'b0;
      mode <= ~m;
      fs <= ~f;
      repeat (20) tick(n, 800);
      chk({low_consumption_operation, th, ss}, {m[0], thr_of(m), f});
      chk(foe, 1'b0);
      chk(fq, 1'b0);
   endtask
   initial
   begin
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         fb <= seed[15:8] & 8'h4F;
         f = (i == 7) ? 3'h1 : seed[2:0];
         do_reset(i[2:0], 1'b0);
         chk(pgoe, 1'b1);
         fb <= pct(thr_of(i[2:0]));
         repeat (8) tick(n, 900);
         rd_reg(4'h4);
         chk(d[2], 1'b1);
         fb <= pct(thr_of(i[2:0])) - 8'h01;
         repeat (8) tick(n, 900);
         rd_reg(4'h4);
         chk(d[2], 1'b0);
      end
      rd_reg(4'h0);
      chk(d, 32'h400);
      rd_reg(4'h8);
      chk(d, 32'h0);
      @(posedge mclk);
      addr <= 4'h0;
      wd <= 32'h20;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      rd_reg(4'h0);
      chk(d, 32'h20);
      fb <= 8'h60 | seed[7:0];
      n = 0;
      while (pgoe !== 1'b0) tick(n, 200);
      chk(n >= 37 && n <= 39, 1'b1);
      chk(pg, 1'b0);
      fb <= 8'h5F;
      repeat (6) tick(n, 300);
      chk(pgoe, 1'b1);
      fb <= 8'h60;
      repeat (20) tick(n, 300);
      chk(pgoe, 1'b1);
      gap();
      gap();
      chk(n, 500);
      n = 0;
      while (loe !== 1'b1) tick(n, 600);
      chk(lq, 1'b1);
      run <= 1'b1;
      repeat (7000) @(posedge mclk);
      rd_reg(4'h4);
      chk(d[4:3], 2'h1);
      gap();
      gap();
      chk(n >= 413 && n <= 421, 1'b1);
      run <= 1'b0;
      repeat (3000) @(posedge mclk);
      rd_reg(4'h4);
      chk(d[4:3], 2'h0);
      f = 3'h3;
      do_reset(3'h0, 1'b1);
      rd_reg(4'h4);
      chk(d[4:3], 2'h3);
      gap();
      gap();
      chk(n, 1000);
      summarize();
   end
endmodule // tb
`default_nettype wire
